// ==== pig_gate_dispatch.sv ====
// Purpose: Protected-mode interrupt/trap gate delivery sequence behind an APB slave
// Assumes: Descriptor and task state contents are supplied by software registers
// Notes: Function
// Function
// - Nonconforming code below current level, not v86: take inter-privilege path.
// - Same case in v86: fault with code selector unless code level 0, else v86 path.
// - Not lower: v86 faults; conforming or equal enters same level; else fault.
// - 32-bit task segment: entry at level*8+4, fault if entry+7 beyond limit.
// - 16-bit task segment: entry at level*4+2, fault if entry+4 beyond limit.
// - Null stack selector, bad index or requested level mismatch raise task fault.
// - Stack descriptor level mismatch or not writable data raise task fault.
// - Stack segment not present raises stack fault with selector.
// - Inter path needs 24/20 bytes (32-bit) or 12/10 (16-bit) of room.
// - Gate pointer beyond code limit raises protection fault with code 0.
// - 32-bit inter frame: stack, flags, return pointer, error; selectors padded.
// - 16-bit inter frame: same order, 2-word pointers, 2-byte error code.
// - Inter entry sets level, code requested level, clears flags as listed.
// - V86 path needs 40/36 bytes (32-bit) or 20/18 (16-bit) of room.
// - V86 saves flags, clears v86/step/resume, interrupt only for interrupt gates, uses ring 0 stack.
// - V86 pushes four data selectors, old stack, flags, code selector, pointer.
// - V86 zeroes data selectors, loads gate selector and pointer, masked if 16-bit.
// - Same-level path needs 16/12 or 8/6 bytes, else stack fault code 0.
// - 32-bit same-level frame: flags, padded return pointer, then error code.
// - 16-bit same-level frame: flags, two-word return pointer, then error code.
`include "pig_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pig_gate_dispatch
  import pig_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  output logic busy_out
);

  // ****************************************
  // Storage
  // ****************************************
  pig_state_e state, next_state;
  logic [5:0] ctrl;
  logic [1:0] current_priv_level;
  logic [31:0] flags, cur_sel, cur_sp, cur_ip, dseg, xseg;
  logic [15:0] gate_sel, tss_sel, tss_ss;
  logic [31:0] gate_ip, code_limit, tss_limit, tss_sp, tbl_limit, err_code;
  logic [2:0] code_desc;
  logic [3:0] stk_desc;
  logic done;
  pig_fault_s fault;
  pig_path_e path_seen;
  logic [3:0] push_idx;
  logic [31:0] frame [0:9];
  // Declared early: the read mux and the checks use these before their drivers
  logic [31:0] tss_addr;
  logic [31:0] need;

  function automatic logic [31:0] sel_err(input logic [15:0] s, input logic e);
    sel_err = {16'h0000, s[15:2], 1'b0, e};
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic setup = psel_in & ~penable_in;
  wire logic wr_take = psel_in & penable_in & pready_out & pwrite_in;
  wire logic idle = (state == PIG_S_IDLE);
  // Writes while a delivery runs are dropped so the frame sees stable inputs
  wire logic wr_ok = wr_take & idle;
  wire logic [7:0] foff = paddr_in - `PIG_OFF_FRAME;
  wire logic [3:0] fidx = foff[5:2];
  wire logic frame_hit = paddr_in[7] & (foff[7:6] == 2'h0) & (fidx < `PIG_FRAME_DEPTH);
  wire logic start = wr_ok & (paddr_in == `PIG_OFF_CTRL) & pwdata_in[`PIG_CTRL_START];

  logic [31:0] rd_val;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr_in)
      `PIG_OFF_CTRL: rd_val = {26'h0, ctrl[5:1], 1'b0};
      `PIG_OFF_CPL: rd_val = {30'h0, current_priv_level};
      `PIG_OFF_FLAGS: rd_val = flags;
      `PIG_OFF_CUR_SEL: rd_val = cur_sel;
      `PIG_OFF_CUR_SP: rd_val = cur_sp;
      `PIG_OFF_CUR_IP: rd_val = cur_ip;
      `PIG_OFF_DSEG: rd_val = dseg;
      `PIG_OFF_XSEG: rd_val = xseg;
      `PIG_OFF_GATE_SEL: rd_val = {16'h0, gate_sel};
      `PIG_OFF_GATE_IP: rd_val = gate_ip;
      `PIG_OFF_CODE_DESC: rd_val = {29'h0, code_desc};
      `PIG_OFF_CODE_LIMIT: rd_val = code_limit;
      `PIG_OFF_TSS_SEL: rd_val = {16'h0, tss_sel};
      `PIG_OFF_TSS_LIMIT: rd_val = tss_limit;
      `PIG_OFF_TSS_SS: rd_val = {16'h0, tss_ss};
      `PIG_OFF_TSS_SP: rd_val = tss_sp;
      `PIG_OFF_STK_DESC: rd_val = {28'h0, stk_desc};
      `PIG_OFF_TBL_LIMIT: rd_val = tbl_limit;
      `PIG_OFF_ERR_CODE: rd_val = err_code;
      `PIG_OFF_STATUS: rd_val = {24'h0, path_seen, fault.kind, 1'b0,
                                 fault.kind != PIG_F_NONE, done, ~idle};
      `PIG_OFF_FAULT_CODE: rd_val = fault.code;
      `PIG_OFF_TSS_ADDR: rd_val = tss_addr;
      default: begin
        rd_hit = frame_hit;
        rd_val = frame_hit ? frame[fidx] : 32'h0000_0000;
      end
    endcase
  end

  // ****************************************
  // Privilege dispatch and checks
  // ****************************************
  wire logic has_err = ctrl[`PIG_CTRL_HAS_ERR];
  wire logic gate32 = ctrl[`PIG_CTRL_GATE32];
  wire logic int_gate = ctrl[`PIG_CTRL_INT_GATE];
  wire logic tss32 = ctrl[`PIG_CTRL_TSS32];
  wire logic outside_source_bit = ctrl[`PIG_CTRL_EXT];
  wire logic v86 = flags[`PIG_FL_VM];
  wire logic [1:0] code_dpl = code_desc[1:0];
  wire logic conform = code_desc[`PIG_DESC_CONFORM];
  wire logic nc_lower = ~conform & (code_dpl < current_priv_level);
  wire logic [31:0] dpl32 = {30'h0, code_dpl};
  assign tss_addr = tss32 ? (dpl32 << `PIG_TSS32_SHIFT) + `PIG_TSS32_BASE
                          : (dpl32 << `PIG_TSS16_SHIFT) + `PIG_TSS16_BASE;
  wire logic [31:0] tss_end = tss_addr + (tss32 ? `PIG_TSS32_SPAN : `PIG_TSS16_SPAN);
  wire logic tss_lim_bad = tss_end > tss_limit;
  wire logic ss_null = (tss_ss[15:2] == 14'h0);
  wire logic ss_idx_bad = {16'h0, tss_ss[15:3], 3'h7} > tbl_limit;
  wire logic ss_rpl_bad = tss_ss[1:0] != code_dpl;
  wire logic ss_dsc_bad = (stk_desc[1:0] != code_dpl) | ~stk_desc[`PIG_DESC_WRDATA];
  wire logic ip_bad = gate_ip > code_limit;
  wire logic [31:0] ss_code = sel_err(tss_ss, outside_source_bit);

  pig_path_e path;
  pig_fault_s chk;
  logic [3:0] n_items;
  always_comb begin
    chk = '{PIG_F_NONE, 32'h0000_0000};
    path = PIG_P_NONE;
    if (nc_lower) begin
      if (!v86) begin
        path = PIG_P_INTER;
      end else if (code_dpl != `PIG_RING0) begin
        chk = '{PIG_F_GP, sel_err(gate_sel, 1'b0)};
      end else begin
        path = PIG_P_V86;
      end
    end else if (v86) begin
      chk = '{PIG_F_GP, sel_err(gate_sel, 1'b0)};
    end else if (conform || code_dpl == current_priv_level) begin
      path = PIG_P_INTRA;
    end else begin
      chk = '{PIG_F_GP, sel_err(gate_sel, outside_source_bit)};
    end
    // First failing check wins; later ones are not looked at
    if (path == PIG_P_INTER || path == PIG_P_V86) begin
      if (tss_lim_bad) begin
        chk = '{PIG_F_TS, sel_err(tss_sel, 1'b0)};
      end else if (ss_null) begin
        chk = '{PIG_F_TS, {31'h0, outside_source_bit}};
      end else if (ss_idx_bad || ss_rpl_bad) begin
        chk = '{PIG_F_TS, ss_code};
      end else if (ss_dsc_bad) begin
        chk = '{PIG_F_TS, ss_code};
      end else if (!stk_desc[`PIG_DESC_PRESENT]) begin
        chk = '{PIG_F_SS, ss_code};
      end else if (tss_sp < need) begin
        chk = '{PIG_F_SS, ss_code};
      end else if (ip_bad) begin
        chk = '{PIG_F_GP, 32'h0000_0000};
      end
    end else if (path == PIG_P_INTRA) begin
      if (cur_sp < need) begin
        chk = '{PIG_F_SS, 32'h0000_0000};
      end else if (ip_bad) begin
        chk = '{PIG_F_GP, 32'h0000_0000};
      end
    end
  end

  // Frame size in items times item width gives the room figures
  assign n_items = (path == PIG_P_V86 ? `PIG_ITEMS_V86 :
                    path == PIG_P_INTER ? `PIG_ITEMS_INTER : `PIG_ITEMS_INTRA)
                   + {3'h0, has_err};
  assign need = {28'h0, n_items} << (gate32 ? `PIG_SHIFT_W32 : `PIG_SHIFT_W16);

  // ****************************************
  // Frame contents in push order
  // ****************************************
  wire logic [31:0] wmask = gate32 ? 32'hFFFF_FFFF : `PIG_IP16_MASK;
  logic [31:0] item [0:9];
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      item[i] = 32'h0000_0000;
    end
    unique case (path)
      PIG_P_INTER: begin
        item[0] = {16'h0, cur_sel[15:0]};
        item[1] = cur_sp & wmask;
        item[2] = flags & wmask;
        item[3] = {16'h0, cur_sel[31:16]};
        item[4] = cur_ip & wmask;
        item[5] = err_code & wmask;
      end
      PIG_P_V86: begin
        item[0] = {16'h0, xseg[31:16]};
        item[1] = {16'h0, xseg[15:0]};
        item[2] = {16'h0, dseg[31:16]};
        item[3] = {16'h0, dseg[15:0]};
        item[4] = {16'h0, cur_sel[15:0]};
        item[5] = cur_sp & wmask;
        item[6] = flags & wmask;
        item[7] = {16'h0, cur_sel[31:16]};
        item[8] = cur_ip & wmask;
        item[9] = err_code & wmask;
      end
      PIG_P_INTRA: begin
        item[0] = flags & wmask;
        item[1] = {16'h0, cur_sel[31:16]};
        item[2] = cur_ip & wmask;
        item[3] = err_code & wmask;
      end
      PIG_P_NONE: ;
    endcase
  end

  // ****************************************
  // Entry state
  // ****************************************
  wire logic to_intra = (path == PIG_P_INTRA);
  wire logic to_v86 = (path == PIG_P_V86);
  wire logic [1:0] new_cpl = to_intra ? current_priv_level : code_dpl;
  wire logic [15:0] new_cs = to_v86 ? gate_sel : {gate_sel[15:2], new_cpl};
  wire logic [15:0] new_ss = to_intra ? cur_sel[15:0] : tss_ss;
  wire logic [31:0] new_sp = (to_intra ? cur_sp : tss_sp) - need;
  wire logic [31:0] new_ip = gate_ip & wmask;
  wire logic [31:0] clr_mask = (32'h1 << `PIG_FL_TF) | (32'h1 << `PIG_FL_VM)
                             | (32'h1 << `PIG_FL_RF)
                             | (to_v86 ? 32'h0 : (32'h1 << `PIG_FL_NT))
                             | (int_gate ? (32'h1 << `PIG_FL_IF) : 32'h0);
  wire logic fin = (state == PIG_S_FIN);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      PIG_S_IDLE: if (start) next_state = PIG_S_CHECK;
      PIG_S_CHECK: next_state = (chk.kind == PIG_F_NONE) ? PIG_S_PUSH : PIG_S_IDLE;
      PIG_S_PUSH: if (push_idx == n_items - 4'h1) next_state = PIG_S_FIN;
      PIG_S_FIN: next_state = PIG_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= PIG_S_IDLE;
      push_idx <= 4'h0;
      busy_out <= 1'b0;
    end else begin
      state <= next_state;
      push_idx <= (state == PIG_S_PUSH) ? push_idx + 4'h1 : 4'h0;
      busy_out <= (next_state != PIG_S_IDLE);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (state == PIG_S_PUSH) begin
      frame[push_idx] <= item[push_idx];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      done <= 1'b0;
      fault <= '{PIG_F_NONE, 32'h0000_0000};
      path_seen <= PIG_P_NONE;
    end else if (start) begin
      done <= 1'b0;
      fault <= '{PIG_F_NONE, 32'h0000_0000};
    end else if (state == PIG_S_CHECK) begin
      fault <= chk;
      path_seen <= path;
      done <= (chk.kind != PIG_F_NONE);
    end else if (fin) begin
      done <= 1'b1;
    end
  end

  // ****************************************
  // Software registers and architectural update
  // ****************************************
  wire logic w_at_cpl = wr_ok & (paddr_in == `PIG_OFF_CPL);
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctrl <= 6'h00;
      current_priv_level <= 2'h0;
      flags <= 32'h0000_0000;
      cur_sel <= 32'h0000_0000;
      cur_sp <= 32'h0000_0000;
      cur_ip <= 32'h0000_0000;
      dseg <= 32'h0000_0000;
      xseg <= 32'h0000_0000;
    end else if (fin) begin
      // Only reached when every check passed
      current_priv_level <= new_cpl;
      flags <= flags & ~clr_mask;
      cur_sel <= {new_cs, new_ss};
      cur_sp <= new_sp;
      cur_ip <= new_ip;
      if (to_v86) begin
        dseg <= 32'h0000_0000;
        xseg <= 32'h0000_0000;
      end
    end else if (wr_ok) begin
      if (paddr_in == `PIG_OFF_CTRL) ctrl <= {pwdata_in[5:1], 1'b0};
      if (w_at_cpl) current_priv_level <= pwdata_in[1:0];
      if (paddr_in == `PIG_OFF_FLAGS) flags <= pwdata_in;
      if (paddr_in == `PIG_OFF_CUR_SEL) cur_sel <= pwdata_in;
      if (paddr_in == `PIG_OFF_CUR_SP) cur_sp <= pwdata_in;
      if (paddr_in == `PIG_OFF_CUR_IP) cur_ip <= pwdata_in;
      if (paddr_in == `PIG_OFF_DSEG) dseg <= pwdata_in;
      if (paddr_in == `PIG_OFF_XSEG) xseg <= pwdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gate_sel <= 16'h0000;
      gate_ip <= 32'h0000_0000;
      code_desc <= 3'h0;
      code_limit <= 32'h0000_0000;
      tss_sel <= 16'h0000;
      tss_limit <= 32'h0000_0000;
      tss_ss <= 16'h0000;
      tss_sp <= 32'h0000_0000;
      stk_desc <= 4'h0;
      tbl_limit <= 32'h0000_0000;
      err_code <= 32'h0000_0000;
    end else if (wr_ok) begin
      if (paddr_in == `PIG_OFF_GATE_SEL) gate_sel <= pwdata_in[15:0];
      if (paddr_in == `PIG_OFF_GATE_IP) gate_ip <= pwdata_in;
      if (paddr_in == `PIG_OFF_CODE_DESC) code_desc <= pwdata_in[2:0];
      if (paddr_in == `PIG_OFF_CODE_LIMIT) code_limit <= pwdata_in;
      if (paddr_in == `PIG_OFF_TSS_SEL) tss_sel <= pwdata_in[15:0];
      if (paddr_in == `PIG_OFF_TSS_LIMIT) tss_limit <= pwdata_in;
      if (paddr_in == `PIG_OFF_TSS_SS) tss_ss <= pwdata_in[15:0];
      if (paddr_in == `PIG_OFF_TSS_SP) tss_sp <= pwdata_in;
      if (paddr_in == `PIG_OFF_STK_DESC) stk_desc <= pwdata_in[3:0];
      if (paddr_in == `PIG_OFF_TBL_LIMIT) tbl_limit <= pwdata_in;
      if (paddr_in == `PIG_OFF_ERR_CODE) err_code <= pwdata_in;
    end
  end

  // ****************************************
  // APB answer, one wait-free access phase
  // ****************************************
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      prdata_out <= (setup & ~pwrite_in) ? rd_val : 32'h0000_0000;
      pslverr_out <= setup & ~rd_hit;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  inter_path_taken_a: assert property ((state == PIG_S_CHECK) && nc_lower && !v86
    |=> path_seen == PIG_P_INTER) else $error("inter path not taken");
  v86_gp_fault_a: assert property ((state == PIG_S_CHECK) && nc_lower && v86 && code_dpl != 2'h0
    |=> fault.kind == PIG_F_GP && fault.code == {16'h0, $past(gate_sel[15:2]), 2'h0})
    else $error("v86 entry to nonzero level not faulted");
  same_level_a: assert property ((state == PIG_S_CHECK) && !nc_lower && !v86 && conform
    |=> path_seen == PIG_P_INTRA) else $error("conforming entry not same level");
  tss_limit_a: assert property ((state == PIG_S_CHECK) && !to_intra && chk.kind == PIG_F_NONE
    |-> tss_end <= tss_limit && tss_addr == (tss32 ? dpl32 * 8 + 4 : dpl32 * 4 + 2))
    else $error("task stack entry beyond limit accepted");
  null_stack_a: assert property ((state == PIG_S_CHECK) && !to_intra && !tss_lim_bad && ss_null
    && path != PIG_P_NONE |=> fault.kind == PIG_F_TS && fault.code == {31'h0, $past(outside_source_bit)})
    else $error("null stack selector not faulted");
  room_check_a: assert property ((state == PIG_S_CHECK) && chk.kind == PIG_F_NONE
    |-> (to_intra ? cur_sp : tss_sp) >= n_items * (gate32 ? 4 : 2))
    else $error("stack room not enforced");
  ip_limit_a: assert property ((state == PIG_S_CHECK) && ip_bad
    |=> fault.kind != PIG_F_NONE && state == PIG_S_IDLE) else $error("gate pointer limit ignored");
  push_count_a: assert property ((state == PIG_S_CHECK) && chk.kind == PIG_F_NONE
    |=> (state == PIG_S_PUSH)[*3] ##0 push_idx == 4'h2) else $error("frame push too short");
  inter_flags_a: assert property (fin && path == PIG_P_INTER
    |=> !flags[`PIG_FL_TF] && !flags[`PIG_FL_NT] && !flags[`PIG_FL_VM] && current_priv_level == $past(code_dpl))
    else $error("inter entry state wrong");
  v86_segs_a: assert property (fin && to_v86
    |=> dseg == 32'h0 && xseg == 32'h0 && current_priv_level == 2'h0) else $error("v86 segments not cleared");
  fault_stable_a: assert property ((state == PIG_S_CHECK) && chk.kind != PIG_F_NONE
    |=> $stable(flags) && $stable(current_priv_level) && $stable(cur_sp) && $stable(cur_sel))
    else $error("state changed on fault");

  inter_done_c: cover property (fin && path == PIG_P_INTER);
  v86_done_c: cover property (fin && to_v86);
  intra_done_c: cover property (fin && to_intra);
  ts_fault_c: cover property ((state == PIG_S_CHECK) && chk.kind == PIG_F_TS);

endmodule

`default_nettype wire

// ==== pig_gate_dispatch_bench.sv ====
// Purpose: Self-checking bench for the gate dispatch unit
// Assumes: Wait-free APB slave, context loaded through registers 04..48
// Notes: Every case reloads the whole context, so cases do not leak state
`timescale 1ns/1ps
`default_nettype none
module pig_gate_dispatch_bench import pig_pkg::*;;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, busy, rerr;
  logic [31:0] prdata, rdat;
  logic [31:0] bd[18], bd0[18], fr[10];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  pig_gate_dispatch uut (.mclk_in(mclk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .busy_out(busy));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    // Global cycle limit bounds this wait
    while (pready !== 1'b1) @(posedge mclk_in);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rdat, e);
  endtask

  task automatic start(input logic [31:0] ctrl);
    for (int i = 0; i < 18; i++) xfer(1'b1, 8'h04 + 8'(4 * i), bd[i]);
    xfer(1'b1, 8'h00, ctrl | 32'h1);
    @(posedge mclk_in);
    chk("busy", {31'h0, busy}, 32'h1);
    do xfer(1'b0, 8'h4C, 32'h0); while (rdat[1] !== 1'b1);
  endtask

  task automatic fcase(input int i1, input logic [31:0] v1, input int i2,
      input logic [31:0] v2, input logic [31:0] ctrl, input pig_fault_e k,
      input logic [31:0] code);
    bd = bd0;
    bd[i1] = v1;
    bd[i2] = v2;
    start(ctrl);
    chk("fault status", {26'h0, rdat[5:0]}, {26'h0, k, 4'h6});
    rdc(8'h50, code);
    rdc(8'h04, bd[0]);
  endtask

  task automatic scase(input logic [31:0] ctrl, input logic [7:0] st, input int n);
    start(ctrl);
    chk("status", rdat, {24'h0, st});
    chk("busy idle", {31'h0, busy}, 32'h0);
    for (int i = 0; i < n; i++) rdc(8'h80 + 8'(4 * i), fr[i]);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    // Ring 3 caller, ring 0 target, all selectors in range
    bd0 = '{32'h3, 32'h0001_4301, 32'h0023_002B, 32'h8000, 32'h1234, 32'h0033_0044,
      32'h0055_0066, 32'h10, 32'h100, 32'h0, 32'hFFFF, 32'h28, 32'h67, 32'h18, 32'h1000,
      32'hC, 32'hFFFF, 32'h0001_ABCD};
    repeat (6) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    xfer(1'b0, 8'h60, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    bd = bd0;
    fr = '{32'h2B, 32'h8000, 32'h0001_4301, 32'h23, 32'h1234, 0, 0, 0, 0, 0};
    scase(32'h1C, 8'h42, 5);
    rdc(8'h54, 32'h4);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h1);
    rdc(8'h0C, 32'h0010_0018);
    rdc(8'h10, 32'hFEC);
    bd = bd0;
    bd[0] = 32'h0;
    fr = '{32'h4301, 32'h23, 32'h1234, 32'hABCD, 0, 0, 0, 0, 0, 0};
    scase(32'h02, 8'hC2, 4);
    rdc(8'h08, 32'h201);
    rdc(8'h10, 32'h7FF8);
    bd = bd0;
    bd[1] = 32'h0002_4301;
    fr = '{32'h55, 32'h66, 32'h33, 32'h44, 32'h2B, 32'h8000, 32'h0002_4301, 32'h23,
      32'h1234, 32'h0001_ABCD};
    scase(32'h1E, 8'h82, 10);
    rdc(8'h08, 32'h4001);
    rdc(8'h18, 32'h0);
    rdc(8'h1C, 32'h0);
    rdc(8'h10, 32'hFD8);
    // Faults, with the outside source bit set in all but the same-level room case
    fcase(12, 32'hA, 12, 32'hA, 32'h3C, PIG_F_TS, 32'h28);
    fcase(12, 32'h5, 12, 32'h5, 32'h2C, PIG_F_TS, 32'h28);
    fcase(13, 32'h0, 13, 32'h0, 32'h3C, PIG_F_TS, 32'h1);
    fcase(13, 32'h19, 13, 32'h19, 32'h3C, PIG_F_TS, 32'h19);
    fcase(15, 32'h8, 15, 32'h8, 32'h3C, PIG_F_TS, 32'h19);
    fcase(15, 32'hD, 15, 32'hD, 32'h3C, PIG_F_TS, 32'h19);
    fcase(15, 32'h4, 15, 32'h4, 32'h3C, PIG_F_SS, 32'h19);
    fcase(14, 32'h17, 14, 32'h17, 32'h3E, PIG_F_SS, 32'h19);
    fcase(14, 32'h9, 14, 32'h9, 32'h38, PIG_F_SS, 32'h19);
    fcase(8, 32'h0001_0000, 8, 32'h0001_0000, 32'h3C, PIG_F_GP, 32'h0);
    fcase(1, 32'h0002_4301, 9, 32'h1, 32'h3C, PIG_F_GP, 32'h10);
    fcase(1, 32'h0002_4301, 14, 32'h23, 32'h3E, PIG_F_SS, 32'h19);
    fcase(0, 32'h0, 9, 32'h1, 32'h3C, PIG_F_GP, 32'h11);
    fcase(0, 32'h0, 3, 32'hB, 32'h1C, PIG_F_SS, 32'h0);
    fcase(13, 32'h0, 14, 32'h0, 32'h3C, PIG_F_TS, 32'h1);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== pig_pkg.sv ====
// Purpose: Types shared by the gate dispatch unit
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in pig_regs.svh
package pig_pkg;
  typedef enum logic [1:0] {
    PIG_S_IDLE = 2'h0,
    PIG_S_CHECK = 2'h1,
    PIG_S_PUSH = 2'h3,
    PIG_S_FIN = 2'h2
  } pig_state_e;

  typedef enum logic [1:0] {
    PIG_F_NONE = 2'h0,
    PIG_F_GP = 2'h1,
    PIG_F_TS = 2'h2,
    PIG_F_SS = 2'h3
  } pig_fault_e;

  typedef enum logic [1:0] {
    PIG_P_NONE = 2'h0,
    PIG_P_INTER = 2'h1,
    PIG_P_V86 = 2'h2,
    PIG_P_INTRA = 2'h3
  } pig_path_e;

  typedef struct packed {
    pig_fault_e kind;
    logic [31:0] code;
  } pig_fault_s;
endpackage

// ==== pig_regs.svh ====
// Purpose: Register offsets, field positions and sizing constants for the gate dispatch unit
// Assumes: 32-bit APB data, byte addresses, every register one aligned word
// Notes: Definitions only
`ifndef PIG_REGS_SVH
`define PIG_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PIG_OFF_CTRL 8'h00
`define PIG_OFF_CPL 8'h04
`define PIG_OFF_FLAGS 8'h08
`define PIG_OFF_CUR_SEL 8'h0C
`define PIG_OFF_CUR_SP 8'h10
`define PIG_OFF_CUR_IP 8'h14
`define PIG_OFF_DSEG 8'h18
`define PIG_OFF_XSEG 8'h1C
`define PIG_OFF_GATE_SEL 8'h20
`define PIG_OFF_GATE_IP 8'h24
`define PIG_OFF_CODE_DESC 8'h28
`define PIG_OFF_CODE_LIMIT 8'h2C
`define PIG_OFF_TSS_SEL 8'h30
`define PIG_OFF_TSS_LIMIT 8'h34
`define PIG_OFF_TSS_SS 8'h38
`define PIG_OFF_TSS_SP 8'h3C
`define PIG_OFF_STK_DESC 8'h40
`define PIG_OFF_TBL_LIMIT 8'h44
`define PIG_OFF_ERR_CODE 8'h48
`define PIG_OFF_STATUS 8'h4C
`define PIG_OFF_FAULT_CODE 8'h50
`define PIG_OFF_TSS_ADDR 8'h54
`define PIG_OFF_FRAME 8'h80
`define PIG_FRAME_DEPTH 4'hA

// ****************************************
// Field positions
// ****************************************
`define PIG_CTRL_START 0
`define PIG_CTRL_HAS_ERR 1
`define PIG_CTRL_GATE32 2
`define PIG_CTRL_INT_GATE 3
`define PIG_CTRL_TSS32 4
`define PIG_CTRL_EXT 5
`define PIG_DESC_CONFORM 2
`define PIG_DESC_WRDATA 2
`define PIG_DESC_PRESENT 3
`define PIG_FL_TF 8
`define PIG_FL_IF 9
`define PIG_FL_NT 14
`define PIG_FL_RF 16
`define PIG_FL_VM 17

// ****************************************
// Sizing constants
// ****************************************
`define PIG_ITEMS_INTER 4'h5
`define PIG_ITEMS_V86 4'h9
`define PIG_ITEMS_INTRA 4'h3
`define PIG_SHIFT_W32 5'h2
`define PIG_SHIFT_W16 5'h1
`define PIG_TSS32_SHIFT 5'h3
`define PIG_TSS16_SHIFT 5'h2
`define PIG_TSS32_BASE 32'h0000_0004
`define PIG_TSS32_SPAN 32'h0000_0007
`define PIG_TSS16_BASE 32'h0000_0002
`define PIG_TSS16_SPAN 32'h0000_0004
`define PIG_IP16_MASK 32'h0000_FFFF
`define PIG_RING0 2'h0

`endif
